// [include/ems_pkg.sv]
/*
 * Constants for the external memory select and strobe block.
 * Assumes a single 50 MHz system clock and active-low asynchronous reset.
 */
`default_nettype none
package ems_pkg;
    localparam int ADDR_W = 24;            // external address width
    localparam int BANK_MSB = 23;          // bank field top bit
    localparam int BANK_LSB = 22;          // bank field low bit
    localparam int NUM_BANKS = 4;
    localparam int ADDR_TEN_BIT = 10;
    localparam logic [3:0] BANKS_IDLE = 4'hF;
    localparam logic [1:0] SEL_MODE_MEM = 2'h2;  // shared pin in bank select mode
    localparam logic [1:0] SEL_MODE_FLAG = 2'h0;
    localparam logic [1:0] SEL_MODE_ALT = 2'h1;  // interrupt / timer function
    typedef enum logic [1:0] {
        EMS_IDLE = 2'b00,
        EMS_ADDR = 2'b01,
        EMS_STROBE = 2'b11,
        EMS_DONE = 2'b10
    } ems_state_t;
endpackage
`default_nettype wire

// [hw/ems_ctrl.sv]
/*
 * External memory select and strobe logic: bank selects, read and write
 * strobes, wait-state acknowledge, sdram address-ten and clock gate.
 * Assumes the processor side presents one request at a time and holds
 * address and data-direction stable until done_out pulses.
 */
// Summary of operation
// - drive the addressed bank select low while that bank is accessed
// - bank selects decoded from address, change with the address lines
// - all bank selects high when no external access is running
// - conditional access asserts bank select even when condition is false
// - sdram address-ten line replaces address bit ten during sdram accesses
// - sdram clock gate output enables or disables sdram clocking
// - selects two and three share flag pins; pull-up only in select mode
// - read strobe low per word read, write strobe low per word written
`default_nettype none
module ems_ctrl #(
    parameter int ADDR_W = ems_pkg::ADDR_W
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic req_in,
    input wire logic write_in,
    input wire logic cond_pass_in,
    input wire logic is_sdram_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic ack_in,
    input wire logic cfg_done_in,
    input wire logic clock_gate_req_in,
    input wire logic sdram_addr_ten_in,
    input wire logic [1:0] sel2_mode_in,
    input wire logic [1:0] sel3_mode_in,
    input wire logic flag2_out_in,
    input wire logic flag2_oe_in,
    input wire logic flag3_out_in,
    input wire logic flag3_oe_in,
    input wire logic timer_expired_in,
    output logic [1:0] bank_select_n_out,
    output logic shared_flag_irq_select_two_out,
    output logic shared_flag_irq_select_two_oe_out,
    output logic shared_flag_irq_select_two_pu_out,
    output logic shared_flag_timer_select_three_out,
    output logic shared_flag_timer_select_three_oe_out,
    output logic shared_flag_timer_select_three_pu_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic address_bit_ten_out,
    output logic sdram_precharge_addr_line_out,
    output logic sdram_clock_gate_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic busy_out,
    output logic done_out
);
    ems_pkg::ems_state_t state_ff;
    ems_pkg::ems_state_t nxt_state;
    logic [3:0] sel_n_ff;
    logic [1:0] shared_pin_ff;
    logic [1:0] shared_oe_ff;
    logic [1:0] shared_pu_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic a10_ff;
    logic sdram_precharge_addr_line_ff;
    logic cke_ff;
    logic rd_n_ff;
    logic wr_n_ff;
    logic done_ff;
    logic xfer_ff;
    logic sdram_ff;
    logic [3:0] nxt_sel_n;
    logic busy_ff;
    // one-hot active-low bank decode from the top address bits
    function automatic logic [3:0] bank_decode(input logic [ADDR_W-1:0] a);
        logic [3:0] r;
        r = ems_pkg::BANKS_IDLE;
        r[a[ems_pkg::BANK_MSB:ems_pkg::BANK_LSB]] = 1'b0;
        return r;
    endfunction
    // access sequencer: address phase, strobe phase with waits, done
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ems_pkg::EMS_IDLE:
                if (req_in)
                    nxt_state = ems_pkg::EMS_ADDR;
            ems_pkg::EMS_ADDR:
                nxt_state = ems_pkg::EMS_STROBE;
            ems_pkg::EMS_STROBE:
                if (ack_in)
                    nxt_state = ems_pkg::EMS_DONE;
            ems_pkg::EMS_DONE:
                nxt_state = ems_pkg::EMS_IDLE;
            default:
                nxt_state = ems_pkg::EMS_IDLE;
        endcase
    end
    // sequencer state; reset parks it idle
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
            state_ff <= ems_pkg::EMS_IDLE;
        else
            state_ff <= nxt_state;
    end

    // capture request attributes; a failed condition still selects the bank
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            addr_ff <= '0;
            xfer_ff <= 1'b0;
            sdram_ff <= 1'b0;
        end
        else if (state_ff == ems_pkg::EMS_IDLE && req_in)
        begin
            addr_ff <= addr_in;
            xfer_ff <= cond_pass_in;
            sdram_ff <= is_sdram_in;
        end
    end

    // next select pattern, shared so the flag pins stay aligned with banks 0-1
    always_comb
    begin
        nxt_sel_n = sel_n_ff;
        if (state_ff == ems_pkg::EMS_IDLE && req_in)
            nxt_sel_n = bank_decode(addr_in);
        else if (state_ff == ems_pkg::EMS_DONE)
            nxt_sel_n = ems_pkg::BANKS_IDLE;
    end
    // selects load alongside the address bus and drop once the access ends
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
            sel_n_ff <= ems_pkg::BANKS_IDLE;
        else
            sel_n_ff <= nxt_sel_n;
    end
    // strobes only for a transfer that really happens; one word per access
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
        end
        else
        begin
            rd_n_ff <= !(nxt_state == ems_pkg::EMS_STROBE && xfer_ff && !write_in);
            wr_n_ff <= !(nxt_state == ems_pkg::EMS_STROBE && xfer_ff && write_in);
        end
    end

    // status flags registered so busy and done leave straight from flops
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
            {busy_ff, done_ff} <= 2'h0;
        else
            {busy_ff, done_ff} <= {nxt_state != ems_pkg::EMS_IDLE, nxt_state == ems_pkg::EMS_DONE};
    end
    // address-ten: sdram line takes over only while sdram accesses run
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            a10_ff <= 1'b0;
            sdram_precharge_addr_line_ff <= 1'b1;
        end
        else
        begin
            a10_ff <= (state_ff == ems_pkg::EMS_IDLE && req_in) ?
                addr_in[ems_pkg::ADDR_TEN_BIT] : addr_ff[ems_pkg::ADDR_TEN_BIT];
            if (!cfg_done_in)
                sdram_precharge_addr_line_ff <= 1'b1;
            else if (state_ff == ems_pkg::EMS_IDLE && req_in && is_sdram_in)
                sdram_precharge_addr_line_ff <= addr_in[ems_pkg::ADDR_TEN_BIT];
            else if (!(sdram_ff && state_ff != ems_pkg::EMS_IDLE))
                sdram_precharge_addr_line_ff <= sdram_addr_ten_in; // refresh runs beside other accesses
        end
    end
    // clock gate held high until the controller is configured
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
            cke_ff <= 1'b1;
        else
            cke_ff <= cfg_done_in ? clock_gate_req_in : 1'b1;
    end
    // shared pins: select mode drives the bank select and enables pull-up
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            shared_pin_ff <= 2'h3;
            shared_oe_ff <= 2'h0;
            shared_pu_ff <= 2'h0;
        end
        else
        begin
            shared_pu_ff[0] <= (sel2_mode_in == ems_pkg::SEL_MODE_MEM);
            shared_pu_ff[1] <= (sel3_mode_in == ems_pkg::SEL_MODE_MEM);
            case (sel2_mode_in)
                ems_pkg::SEL_MODE_MEM:
                begin
                    shared_pin_ff[0] <= nxt_sel_n[2];
                    shared_oe_ff[0] <= 1'b1;
                end
                ems_pkg::SEL_MODE_FLAG:
                begin
                    shared_pin_ff[0] <= flag2_out_in;
                    shared_oe_ff[0] <= flag2_oe_in;
                end
                default:
                begin
                    shared_pin_ff[0] <= 1'b1; // interrupt request: input only
                    shared_oe_ff[0] <= 1'b0;
                end
            endcase
            case (sel3_mode_in)
                ems_pkg::SEL_MODE_MEM:
                begin
                    shared_pin_ff[1] <= nxt_sel_n[3];
                    shared_oe_ff[1] <= 1'b1;
                end
                ems_pkg::SEL_MODE_FLAG:
                begin
                    shared_pin_ff[1] <= flag3_out_in;
                    shared_oe_ff[1] <= flag3_oe_in;
                end
                ems_pkg::SEL_MODE_ALT:
                begin
                    shared_pin_ff[1] <= timer_expired_in;
                    shared_oe_ff[1] <= 1'b1;
                end
                default:
                begin
                    shared_pin_ff[1] <= 1'b1;
                    shared_oe_ff[1] <= 1'b0;
                end
            endcase
        end
    end

    assign bank_select_n_out = sel_n_ff[1:0];
    assign shared_flag_irq_select_two_out = shared_pin_ff[0];
    assign shared_flag_irq_select_two_oe_out = shared_oe_ff[0];
    assign shared_flag_irq_select_two_pu_out = shared_pu_ff[0];
    assign shared_flag_timer_select_three_out = shared_pin_ff[1];
    assign shared_flag_timer_select_three_oe_out = shared_oe_ff[1];
    assign shared_flag_timer_select_three_pu_out = shared_pu_ff[1];
    assign addr_out = addr_ff;
    assign address_bit_ten_out = a10_ff;
    assign sdram_precharge_addr_line_out = sdram_precharge_addr_line_ff;
    assign sdram_clock_gate_out = cke_ff;
    assign rd_n_out = rd_n_ff;
    assign wr_n_out = wr_n_ff;
    assign busy_out = busy_ff;
    assign done_out = done_ff;

    a_idle_deselect: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (state_ff == ems_pkg::EMS_IDLE) |-> (sel_n_ff == ems_pkg::BANKS_IDLE))
        else $error("bank select active while idle");
    a_select_decode: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (state_ff == ems_pkg::EMS_IDLE && req_in) |=> (sel_n_ff == bank_decode(addr_ff)))
        else $error("bank select not decoded from address");
    a_select_with_addr: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        $changed(addr_ff) |-> (state_ff == ems_pkg::EMS_ADDR && sel_n_ff != ems_pkg::BANKS_IDLE))
        else $error("address moved without the select");
    a_cond_select: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (state_ff == ems_pkg::EMS_IDLE && req_in && !cond_pass_in) |=>
        (sel_n_ff != ems_pkg::BANKS_IDLE) ##1 (rd_n_ff && wr_n_ff))
        else $error("failed condition must select but not strobe");
    a_ack_wait: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (state_ff == ems_pkg::EMS_STROBE && !ack_in) |=> !done_ff)
        else $error("access completed during wait state");
    a_read_strobe: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (state_ff == ems_pkg::EMS_STROBE && xfer_ff && !write_in) |-> (!rd_n_ff && wr_n_ff))
        else $error("read strobe missing");
    a_write_strobe: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (state_ff == ems_pkg::EMS_STROBE && xfer_ff && write_in) |-> (!wr_n_ff && rd_n_ff))
        else $error("write strobe missing");
    a_unconfig_high: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        !cfg_done_in |=> (cke_ff && sdram_precharge_addr_line_ff))
        else $error("clock gate or address-ten low before configuration");
    a_cke_follow: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        cfg_done_in |=> (cke_ff == $past(clock_gate_req_in)))
        else $error("clock gate does not follow request");
    a_pullup_mode: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (sel3_mode_in != ems_pkg::SEL_MODE_MEM) |=> !shared_pu_ff[1])
        else $error("pull-up outside select mode");
    a_sdram_a10: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (cfg_done_in && state_ff == ems_pkg::EMS_IDLE && req_in && is_sdram_in) |=>
        (sdram_precharge_addr_line_ff == addr_ff[ems_pkg::ADDR_TEN_BIT]))
        else $error("address-ten not carried on sdram line");
endmodule
`default_nettype wire

// [testbench/ems_mem_model.sv]
/*
 * Far-side memory model: answers each strobe with a programmable number
 * of wait states on the acknowledge line.
 * Assumes strobes come from registers in the clk_sys_in domain.
 */
`default_nettype none
module ems_mem_model (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [1:0] wait_cycles_in,
    output logic ack_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_cnt_ff;

    // count strobe-low cycles; restarts whenever both strobes are high
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
            wait_cnt_ff <= 3'h0;
        else if (rd_n_in && wr_n_in)
            wait_cnt_ff <= 3'h0;
        else
            wait_cnt_ff <= wait_cnt_ff + 3'h1;
    end

    // pulled high when idle, low for the asked wait states
    assign ack_out = (rd_n_in && wr_n_in) ? 1'b1 : (wait_cnt_ff >= {1'b0, wait_cycles_in});
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
/*
 * Self-checking bench for the memory select and strobe block.
 * Assumes the memory model file is compiled first.
 */
`default_nettype none
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin failures++; $display("MISMATCH t=%0t %s", $time, m); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 1'b0, resetn_in = 1'b0, req_in = 1'b0, write_in = 1'b0;
    logic cond_pass_in = 1'b1, is_sdram_in = 1'b0, cfg_done_in = 1'b0, gate_req = 1'b0;
    logic ten_in = 1'b0, ack, rd_n, wr_n, busy, done, sdram_precharge_addr_line, cke, a10;
    logic [23:0] addr_in = 24'h0, addr_out;
    logic [1:0] mode = ems_pkg::SEL_MODE_MEM, waits = 2'h0, sel_n;
    logic s2, s2_oe, s2_pu, s3, s3_oe, s3_pu;
    logic [3:0] sel4;
    logic tmr = 1'b0;
    logic [3:0] fl = 4'h0;
    int failures = 0, num_checks = 0;

    ems_ctrl uut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .req_in(req_in),
        .write_in(write_in), .cond_pass_in(cond_pass_in), .is_sdram_in(is_sdram_in),
        .addr_in(addr_in), .ack_in(ack), .cfg_done_in(cfg_done_in),
        .clock_gate_req_in(gate_req), .sdram_addr_ten_in(ten_in), .sel2_mode_in(mode),
        .sel3_mode_in(mode), .flag2_out_in(fl[0]), .flag2_oe_in(fl[1]), .flag3_out_in(fl[2]),
        .flag3_oe_in(fl[3]), .timer_expired_in(tmr), .bank_select_n_out(sel_n),
        .shared_flag_irq_select_two_out(s2), .shared_flag_irq_select_two_oe_out(s2_oe),
        .shared_flag_irq_select_two_pu_out(s2_pu), .shared_flag_timer_select_three_out(s3),
        .shared_flag_timer_select_three_oe_out(s3_oe),
        .shared_flag_timer_select_three_pu_out(s3_pu), .addr_out(addr_out),
        .address_bit_ten_out(a10), .sdram_precharge_addr_line_out(sdram_precharge_addr_line),
        .sdram_clock_gate_out(cke), .rd_n_out(rd_n), .wr_n_out(wr_n), .busy_out(busy),
        .done_out(done));

    ems_mem_model mem (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .rd_n_in(rd_n),
        .wr_n_in(wr_n), .wait_cycles_in(waits), .ack_out(ack));

    always #10 clk_sys_in = ~clk_sys_in;
    // combined view of all four selects, valid while shared pins are in select mode
    assign sel4 = {s3, s2, sel_n};

    // expected select pattern for the addressed bank
    function automatic logic [3:0] exp_sel(input logic [23:0] a);
        return ~(4'h1 << a[23:22]);
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one word access; req drops on the edge that ends the strobe so it is not retaken
    task automatic access(input logic [23:0] a, input logic wr, input logic cond,
                          input logic sd, input logic [1:0] w);
        int n, lowc, strc, exp_n;
        n = 0;
        exp_n = cond ? 3 + w : 3;
        lowc = 0;
        strc = 0;
        @(posedge clk_sys_in);
        addr_in <= a;
        write_in <= wr;
        cond_pass_in <= cond;
        is_sdram_in <= sd;
        waits <= w;
        req_in <= 1'b1;
        ten_in <= 1'($urandom);
        #1 `CHK(sel4, 4'hF, "select active while idle")
        `CHK(busy, 1'b0, "busy while idle")
        while (done !== 1'b1)
        begin
            @(posedge clk_sys_in);
            n++;
            if (n == exp_n)
                req_in <= 1'b0;
            #1;
            if (n > 20)
            begin
                failures++;
                $display("MISMATCH t=%0t access hung", $time);
                report_and_stop();
            end
            if (sel4 !== 4'hF)
            begin
                lowc++;
                `CHK(sel4, exp_sel(a), "wrong bank select")
                `CHK(addr_out, a, "address not with select")
                `CHK(a10, a[10], "address bit ten")
                `CHK(busy, 1'b1, "busy during access")
            end
            if (rd_n !== 1'b1 || wr_n !== 1'b1)
            begin
                strc++;
                `CHK({rd_n, wr_n}, wr ? 2'b10 : 2'b01, "wrong strobe")
                `CHK(sdram_precharge_addr_line, sd ? a[10] : ten_in, "address ten line")
            end
        end
        `CHK(n, exp_n, "done latency")
        `CHK(lowc, exp_n, "select length")
        `CHK(strc, cond ? 1 + w : 0, "strobe count")
    endtask

    initial
    begin
        void'($urandom(27));
        // registers only take reset at the first edge: reset starts low, no falling edge
        @(posedge clk_sys_in);
        #1 `CHK({cke, sdram_precharge_addr_line, sel_n, rd_n, wr_n, busy, done}, 8'hFC, "reset levels")
        `CHK({s2, s3, s2_oe, s3_oe, s2_pu, s3_pu}, 6'h30, "shared pin reset")
        repeat (2) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        #1 `CHK({cke, sdram_precharge_addr_line}, 2'h3, "unconfigured levels")
        `CHK({s2_pu, s3_pu}, 2'h3, "select mode pull-up")
        $display("test reset done");
        // clock gate follows the request once configured
        @(posedge clk_sys_in);
        cfg_done_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        #1 `CHK(cke, 1'b0, "gate off")
        @(posedge clk_sys_in);
        gate_req <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        #1 `CHK(cke, 1'b1, "gate on")
        $display("test clock gate done");
        // corners: every bank, failed condition, long wait, back to back
        for (int b = 0; b < 4; b++)
            access({b[1:0], 22'h000400}, b[0], 1'b1, b[1], 2'h0);
        access(24'hC00400, 1'b0, 1'b0, 1'b1, 2'h3);
        access(24'h400000, 1'b1, 1'b1, 1'b0, 2'h3);
        $display("test corners done");
        repeat (24)
            access(24'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 2'($urandom));
        $display("test random done");
        // flag, alternate and off modes release the select pull-up
        @(posedge clk_sys_in);
        mode <= ems_pkg::SEL_MODE_FLAG;
        fl <= 4'($urandom);
        repeat (3) @(posedge clk_sys_in);
        #1 `CHK({s2_pu, s3_pu}, 2'h0, "flag mode pull-up")
        `CHK({s3_oe, s3, s2_oe, s2}, fl, "flag mode drive")
        @(posedge clk_sys_in);
        mode <= ems_pkg::SEL_MODE_ALT;
        tmr <= 1'($urandom);
        repeat (3) @(posedge clk_sys_in);
        #1 `CHK({s2_pu, s3_pu, s2_oe, s3_oe, s3}, {4'h1, tmr}, "alternate mode")
        @(posedge clk_sys_in);
        mode <= 2'h3;
        repeat (3) @(posedge clk_sys_in);
        #1 `CHK({s2_pu, s3_pu, s2_oe, s3_oe, s2, s3}, 6'h03, "pins off")
        $display("test shared pins done");
        report_and_stop();
    end
endmodule
`default_nettype wire
